// File: shared/hip_pkg.sv
// ==========================================================
// Shared constants and types of the insertion sequencer
package hip_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ      = 125;
  localparam int SLOW_QUAL_NS = 20000;   // Slow detector default qualification
  localparam int FAST_QUAL_NS = 300;     // Fast detector fixed qualification
  localparam int TRIP_CLR_NS  = 150000;  // Least on-request low time to clear a trip
  // Least times round up to whole cycles
  localparam int SLOW_QUAL_CYC = (SLOW_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int FAST_QUAL_CYC = (FAST_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIP_CLR_CYC  = (TRIP_CLR_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
  localparam int CTRL_EXT_DELAY = 0;     // Use the external delay node
  // Status fields
  localparam int ST_STATE_LSB = 0;       // Four bits of sequencer state
  localparam int ST_PGOOD     = 4;
  localparam int ST_FLAG_LOW  = 5;
  localparam int ST_FAST_ARM  = 6;
  localparam int ST_SLOW_ARM  = 7;
  // Event bits, shared by status and mask
  localparam int EV_FAST_TRIP  = 0;
  localparam int EV_SLOW_TRIP  = 1;
  localparam int EV_PGOOD_RISE = 2;
  localparam int EV_PGOOD_FALL = 3;
  localparam int EV_LOCKOUT    = 4;
  localparam int EV_BITS       = 5;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_LOCKOUT, ST_WAIT_ON, ST_CHECK_GATE, ST_T1_UP, ST_T1_DN,
    ST_SOFT, ST_MONITOR, ST_RECOVER, ST_POWER_OFF, ST_TRIPPED
  } hip_state_t;

  // Comparator indications from the analogue side
  typedef struct packed {
    logic supply_lockout_clear;      // Supply above the upper lockout level
    logic supply_lockout;            // Supply below the lower lockout level
    logic on_req;                    // On-request above its threshold
    logic gate_off;                  // Gate drive below its off level
    logic timing_threshold;          // Timing node reached its threshold
    logic tmr_low;                   // Timing node discharged
    logic slow_node_low;             // Slow-delay node below its check level
    logic flag_high;                 // Breaker flag node above its check level
    logic output_good_comparison;    // Output above its good level
    logic sense_slow;                // Sense drop above the slow threshold
    logic sense_fast;                // Sense drop above the fast threshold
    logic delay_node_top;            // Slow-delay node reached its trip level
  } hip_cmp_t;

  // Drive controls toward the analogue side
  typedef struct packed {
    logic gate_pulldown;
    logic gate_charge;
    logic gate_throttle;
    logic tmr_charge;
    logic tmr_discharge;
    logic slow_node_pulldown;
    logic slow_node_charge;
    logic fast_armed;
    logic slow_armed;
  } hip_drv_t;

endpackage

// File: design/hip_seq.sv
`timescale 1ns/1ps
// ==========================================================
// Notes on behaviour
// - No start-up action until the supply clears the upper lockout level.
// - While waiting: gate pulled down, timing node grounded, delay node low.
// - With supply and on-request valid, confirm gate off before first timing.
// - First timing: charge node to threshold, then discharge to end cycle.
// - Soft-start only if delay node low and breaker flag node high.
// - Soft-start arms fast detector and enables gate charging current.
// - Soft-start end with good output: power-good high, slow armed, monitor.
// - On-request low powers off by pulling the gate down.
// - During power-off, output falling below good drives power-good low.
// - Soft-start throttles gate current while sense drop exceeds slow level.
// - Trip pulls gate to ground at once and latches flag low.
// - Armed slow detector trips after drop persists for qualification time.
// - Armed fast detector trips after fixed short qualification time.
// - Optional external delay node replaces the slow default qualification.
// - On-request low long enough clears trip; later rising restarts.
// - Supply below lower level forces lockout with gate pulled low.
// - Output good again: power-good only after a full good timing cycle.
module hip_seq
  import hip_pkg::*;
#(
  parameter int CLR_CYC = TRIP_CLR_CYC   // Shorten for simulation
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Analogue side
  input  wire hip_cmp_t    CMP,
  output hip_drv_t         DRV,
  output logic             PGOOD,
  output logic             FLAG_O,
  output logic             FLAG_OE_N,
  // Interrupt
  output logic             IRQ
);

  // ==========================================================
  // State
  hip_state_t           state_q, state_d;
  hip_drv_t             drv_q, drv_d;
  logic                 pgood_q, pgood_d;
  logic                 flag_oe_n_q;
  logic [5:0]           fast_cnt_q;
  logic [11:0]          slow_cnt_q;
  logic [14:0]          clr_cnt_q;
  logic                 ctrl_ext_q;
  logic [EV_BITS-1:0]   irq_stat_q, irq_mask_q;
  logic [31:0]          prdata_q;
  logic                 pready_q, pslverr_q, irq_q;

  // ==========================================================
  // Detector decode
  wire on_req     = CMP.on_req;
  wire out_good   = CMP.output_good_comparison;
  wire fast_armed = (state_q == ST_SOFT) || (state_q == ST_MONITOR)
                    || (state_q == ST_RECOVER);
  wire slow_armed = (state_q == ST_MONITOR) || (state_q == ST_RECOVER);
  wire fast_hit   = fast_armed && CMP.sense_fast
                    && (fast_cnt_q == 6'(FAST_QUAL_CYC - 1));
  // External delay node or fixed count
  wire slow_fix   = CMP.sense_slow && (slow_cnt_q == 12'(SLOW_QUAL_CYC - 1));
  wire slow_hit   = slow_armed && (ctrl_ext_q ? CMP.delay_node_top : slow_fix);
  wire trip       = fast_hit || slow_hit;
  wire clr_done   = !on_req && (clr_cnt_q == 15'(CLR_CYC - 1));

  // ==========================================================
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // Hold until supply clears the lockout level
      ST_LOCKOUT:    if (CMP.supply_lockout_clear) state_d = ST_WAIT_ON;
      ST_WAIT_ON:    if (on_req) state_d = ST_CHECK_GATE;
      ST_CHECK_GATE: if (!on_req) state_d = ST_WAIT_ON;
                     else if (CMP.gate_off) state_d = ST_T1_UP;
      ST_T1_UP:      if (!on_req) state_d = ST_WAIT_ON;
                     else if (CMP.timing_threshold) state_d = ST_T1_DN;
      // Checks at end of first timing cycle
      ST_T1_DN:      if (!on_req) state_d = ST_WAIT_ON;
                     else if (CMP.tmr_low && CMP.slow_node_low && CMP.flag_high)
                       state_d = ST_SOFT;
      ST_SOFT:       if (CMP.timing_threshold) state_d = ST_MONITOR;
      // Output good again starts a timing cycle
      ST_MONITOR:    if (out_good && !pgood_q && CMP.tmr_low) state_d = ST_RECOVER;
      ST_RECOVER:    if (!out_good) state_d = ST_MONITOR;
                     else if (CMP.timing_threshold) state_d = ST_MONITOR;
      // Leave power-off once the output has fallen
      ST_POWER_OFF:  if (!out_good) state_d = ST_WAIT_ON;
      // Release after a long enough low on-request
      ST_TRIPPED:    if (clr_done) state_d = ST_WAIT_ON;
      default:       state_d = ST_LOCKOUT;
    endcase
    if (!on_req && fast_armed) state_d = ST_POWER_OFF;
    if (trip) state_d = ST_TRIPPED;
    if (CMP.supply_lockout) state_d = ST_LOCKOUT;
  end

  // ==========================================================
  // Drive controls for the next state; registered so outputs match state_q
  always_comb begin
    drv_d = '0;
    drv_d.gate_pulldown      = !((state_d == ST_SOFT) || (state_d == ST_MONITOR)
                                 || (state_d == ST_RECOVER));
    // Charge pump current and fast arming
    drv_d.gate_charge        = !drv_d.gate_pulldown;
    drv_d.fast_armed         = !drv_d.gate_pulldown;
    // Regulate inrush at the slow limit
    drv_d.gate_throttle      = (state_d == ST_SOFT) && CMP.sense_slow;
    drv_d.slow_armed         = (state_d == ST_MONITOR) || (state_d == ST_RECOVER);
    // Timing node charged only in timing cycles
    drv_d.tmr_charge         = (state_d == ST_T1_UP) || (state_d == ST_SOFT)
                               || (state_d == ST_RECOVER);
    // Otherwise the timing node is held to ground
    drv_d.tmr_discharge      = !drv_d.tmr_charge;
    // Delay node charges only while the slow drop persists
    drv_d.slow_node_charge   = drv_d.slow_armed && ctrl_ext_q && CMP.sense_slow;
    drv_d.slow_node_pulldown = !drv_d.slow_node_charge;
  end

  // Power-good rises at soft-start end or after a good recovery cycle
  assign pgood_d = (state_q == ST_SOFT && state_d == ST_MONITOR && out_good)
                || (state_q == ST_RECOVER && state_d == ST_MONITOR && out_good)
                // Held only while the output stays good
                || (pgood_q && out_good && (state_d == ST_MONITOR
                    || state_d == ST_RECOVER || state_d == ST_POWER_OFF));

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q     <= ST_LOCKOUT;
      drv_q       <= '{gate_pulldown: 1'b1, tmr_discharge: 1'b1,
                       slow_node_pulldown: 1'b1, default: 1'b0};
      pgood_q     <= 1'b0;
      flag_oe_n_q <= 1'b1;
    end else begin
      state_q     <= state_d;
      drv_q       <= drv_d;
      pgood_q     <= pgood_d;
      flag_oe_n_q <= (state_d != ST_TRIPPED);
    end
  end

  // Qualification counters; reset on any gap so only a steady drop qualifies
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fast_cnt_q <= '0;
      slow_cnt_q <= '0;
      clr_cnt_q  <= '0;
    end else begin
      fast_cnt_q <= (fast_armed && CMP.sense_fast && !fast_hit) ? fast_cnt_q + 6'h01 : '0;
      slow_cnt_q <= (slow_armed && CMP.sense_slow && !slow_fix) ? slow_cnt_q + 12'h001 : '0;
      clr_cnt_q  <= (state_q == ST_TRIPPED && !on_req && !clr_done)
                    ? clr_cnt_q + 15'h0001 : '0;
    end
  end

  // ==========================================================
  // APB slave: one wait state, access completes when PREADY is high
  wire       apb_go   = PSEL && PENABLE && !pready_q;
  wire       apb_done = PSEL && PENABLE && pready_q;
  wire       hit_ctrl = (PADDR == REG_CTRL);
  wire       hit_stat = (PADDR == REG_STATUS);
  wire       hit_irqs = (PADDR == REG_IRQ_STAT);
  wire       hit_mask = (PADDR == REG_IRQ_MASK);
  wire       mapped   = hit_ctrl || hit_stat || hit_irqs || hit_mask;
  wire [31:0] status_w = {24'h000000, drv_q.slow_armed, drv_q.fast_armed,
                          !flag_oe_n_q, pgood_q, 4'(state_q)};
  wire [31:0] rd_mux  = hit_ctrl ? {31'h00000000, ctrl_ext_q}
                      : hit_stat ? status_w
                      : hit_irqs ? {27'h0000000, irq_stat_q}
                      : hit_mask ? {27'h0000000, irq_mask_q} : 32'h0000_0000;
  // Events
  wire [EV_BITS-1:0] ev = {state_d == ST_LOCKOUT && state_q != ST_LOCKOUT,
                           pgood_q && !pgood_d, !pgood_q && pgood_d,
                           slow_hit && state_q != ST_TRIPPED,
                           fast_hit && state_q != ST_TRIPPED};
  wire rd_clr = apb_done && !PWRITE && hit_irqs;
  // A read clears only the bits it returned, so an event at the capture edge is kept
  wire [EV_BITS-1:0] stat_keep = irq_stat_q & ~prdata_q[EV_BITS-1:0];
  wire [EV_BITS-1:0] stat_next = (rd_clr ? stat_keep : irq_stat_q) | ev;

  // Bus handshake and read data
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_go;
      pslverr_q <= apb_go && !mapped;
      prdata_q  <= (apb_go && !PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // Writable registers, taken at the completing edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_ext_q <= CTRL_RST[CTRL_EXT_DELAY];
      irq_mask_q <= IRQ_MASK_RST[EV_BITS-1:0];
    end else if (apb_done && PWRITE) begin
      if (hit_ctrl) ctrl_ext_q <= PWDATA[CTRL_EXT_DELAY];
      if (hit_mask) irq_mask_q <= PWDATA[EV_BITS-1:0];
    end
  end

  // Sticky events; a new event wins over the read clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= stat_next;
      irq_q      <= |(stat_next & irq_mask_q);
    end
  end

  assign PRDATA    = prdata_q;
  assign PREADY    = pready_q;
  assign PSLVERR   = pslverr_q;
  assign DRV       = drv_q;
  assign PGOOD     = pgood_q;
  assign FLAG_O    = 1'b0 & flag_oe_n_q;   // Open drain: only ever pulls low
  assign FLAG_OE_N = flag_oe_n_q;
  assign IRQ       = irq_q;

  // ==========================================================
  // Checks
  // Independent run length of the slow drop; saturates so it cannot wrap
  logic [12:0] slow_run_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      slow_run_q <= '0;
    end else begin
      slow_run_q <= !(slow_armed && CMP.sense_slow) ? '0
                    : (slow_run_q == 13'h1FFF) ? slow_run_q : slow_run_q + 13'h0001;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_supply_wait: assert property (
    state_q == ST_LOCKOUT && !CMP.supply_lockout_clear |=> state_q == ST_LOCKOUT)
    else $error("left lockout without valid supply");
  a_wait_drives: assert property (
    state_q == ST_WAIT_ON |-> drv_q.gate_pulldown && drv_q.tmr_discharge
                              && drv_q.slow_node_pulldown && !drv_q.gate_charge)
    else $error("waiting state drives wrong");
  a_gate_check: assert property (
    $rose(state_q == ST_T1_UP) |-> $past(CMP.gate_off) && $past(on_req))
    else $error("timing began without gate off");
  a_t1_end: assert property (
    state_q == ST_T1_UP && CMP.timing_threshold && on_req && !CMP.supply_lockout
    |=> state_q == ST_T1_DN && drv_q.tmr_discharge)
    else $error("first timing did not turn down");
  a_soft_entry: assert property (
    $rose(state_q == ST_SOFT) |-> $past(CMP.slow_node_low && CMP.flag_high))
    else $error("soft start without node checks");
  a_soft_drive: assert property (
    state_q == ST_SOFT |-> drv_q.fast_armed && drv_q.gate_charge && !drv_q.slow_armed)
    else $error("soft start drive wrong");
  a_pgood_rise: assert property (
    $rose(pgood_q) |-> state_q == ST_MONITOR && drv_q.slow_armed
                       && $past(state_q == ST_SOFT || state_q == ST_RECOVER))
    else $error("power good rose at wrong point");
  a_power_off: assert property (
    fast_armed && !on_req && !CMP.supply_lockout && !trip
    |=> state_q == ST_POWER_OFF && drv_q.gate_pulldown)
    else $error("power off not obeyed");
  a_pgood_fall: assert property (
    !out_good |=> !pgood_q)
    else $error("power good held with output bad");
  a_trip_latch: assert property (
    trip && !CMP.supply_lockout |=> drv_q.gate_pulldown && !FLAG_OE_N
    ##1 (!FLAG_OE_N [*2]))
    else $error("trip not latched");
  a_fast_qual: assert property (
    $rose(fast_hit) |-> $past(CMP.sense_fast, 37) && $past(CMP.sense_fast, 1))
    else $error("fast trip before qualification");
  a_lockout_now: assert property (
    CMP.supply_lockout |=> state_q == ST_LOCKOUT && drv_q.gate_pulldown && !pgood_q)
    else $error("lockout not entered");
  // First timing, throttle, qualification, release, recovery and power-off checks
  a_t1_wait: assert property (
    state_q == ST_T1_DN && !CMP.tmr_low && on_req && !CMP.supply_lockout
    |=> state_q == ST_T1_DN)
    else $error("first timing ended before discharge");
  a_throttle_on: assert property (
    state_q == ST_SOFT && CMP.sense_slow && on_req && !trip && !CMP.supply_lockout
    && !CMP.timing_threshold |=> drv_q.gate_throttle)
    else $error("inrush not throttled");
  a_throttle_off: assert property (
    !CMP.sense_slow |=> !drv_q.gate_throttle)
    else $error("throttle held after drop ended");
  a_slow_qual: assert property (
    slow_hit && !ctrl_ext_q |-> slow_run_q == 13'(SLOW_QUAL_CYC - 1))
    else $error("slow trip at wrong qualification time");
  a_ext_delay: assert property (
    slow_armed && ctrl_ext_q && !CMP.delay_node_top && !fast_hit
    |=> state_q != ST_TRIPPED)
    else $error("slow trip ignored the delay node");
  a_trip_hold: assert property (
    state_q == ST_TRIPPED && on_req |=> state_q == ST_TRIPPED || state_q == ST_LOCKOUT)
    else $error("trip released with on-request high");
  a_recover_wait: assert property (
    state_q == ST_RECOVER |-> !pgood_q)
    else $error("power good during recovery cycle");
  a_recover_abort: assert property (
    state_q == ST_RECOVER && !out_good && on_req && !trip && !CMP.supply_lockout
    |=> state_q == ST_MONITOR && !pgood_q)
    else $error("recovery not aborted");
  a_off_exit: assert property (
    state_q == ST_POWER_OFF && !out_good && !CMP.supply_lockout
    |=> state_q == ST_WAIT_ON && !pgood_q)
    else $error("power off did not finish");

  c_soft_start: cover property ($rose(state_q == ST_SOFT));
  c_pgood_up:   cover property ($rose(pgood_q));
  c_trip:       cover property ($rose(state_q == ST_TRIPPED));
  c_trip_clear: cover property (state_q == ST_TRIPPED ##1 state_q == ST_WAIT_ON);
  c_recover:    cover property ($rose(state_q == ST_RECOVER));

endmodule // hip_seq

// File: sim/hip_fet_model.sv
`timescale 1ns/1ps
// ==========================================================
// Far side: pass transistor, timing node, delay node and supply
module hip_fet_model
  import hip_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // Bench controls: supply, on-request, output dip, sense drops
  input  wire logic     sup_ok,
  input  wire logic     on_req,
  input  wire logic     dip,
  input  wire logic     s_slow,
  input  wire logic     s_fast,
  // Device side
  input  wire hip_drv_t drv,
  input  wire logic     flag_oe_n,
  output hip_cmp_t      cmp
);
  int gate;
  int tmr;
  int dly;
  // Nodes move one step a cycle (the pulled-down gate falls two), so the device really has to wait on them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate <= 0;
      tmr  <= 0;
      dly  <= 0;
    end else begin
      if (drv.gate_pulldown) gate <= (gate > 2) ? gate - 2 : 0;
      else if (drv.gate_charge && !drv.gate_throttle && gate < 30) gate <= gate + 1;
      if (drv.tmr_charge) tmr <= tmr + 1;
      else if (drv.tmr_discharge && tmr > 0) tmr <= tmr - 1;
      // Pulldown is a weak current, so the node bleeds off slowly after a charge
      dly <= drv.slow_node_charge ? dly + 1 : (dly > 0 ? dly - 1 : 0);
    end
  end
  // Flag node has a pull-up, so it reads high once the device lets go
  assign cmp = {sup_ok, !sup_ok, on_req, gate == 0, tmr >= 24, tmr == 0, dly < 3740,
                flag_oe_n, gate >= 12 && !dip, s_slow, s_fast, dly >= 4000};
endmodule // hip_fet_model

// File: sim/tb.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench of the insertion sequencer
module tb
  import hip_pkg::*;
  ;
  localparam int CLR = 20;
  logic        clk, rst, psel, penable, pwrite, sup_ok, on_req, dip, s_slow, s_fast;
  logic        pready, pslverr, pgood, flag_o, flag_oe_n, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  hip_cmp_t    cmp;
  hip_drv_t    drv;
  int          fails, n_checks, seed;

  // Device and its far side
  hip_seq #(.CLR_CYC(CLR)) i_hip_seq (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CMP(cmp), .DRV(drv), .PGOOD(pgood), .FLAG_O(flag_o),
    .FLAG_OE_N(flag_oe_n), .IRQ(irq));
  hip_fet_model i_hip_fet_model (
    .clk(clk), .rst(rst), .sup_ok(sup_ok), .on_req(on_req), .dip(dip),
    .s_slow(s_slow), .s_fast(s_fast), .drv(drv), .flag_oe_n(flag_oe_n), .cmp(cmp));

  // 125 MHz clock
  always #4 clk = ~clk;

  // ==========================================================
  // Comparison and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected read-back of the event mask: only the event bits are kept
  function automatic logic [31:0] mask_exp(input logic [31:0] w);
    return w & ((32'h1 << EV_BITS) - 32'h1);
  endfunction

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (pready !== 1'b1) begin
      fails++;
      $display("ERROR %0t bus transfer got no answer", $time);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Poll the state field, bounded so a stuck sequencer still ends the run
  task automatic waitst(input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    while (r[3:0] !== s && n < 2000) begin
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      n++;
    end
    chk(32'(r[3:0]), 32'(s));
  endtask

  task automatic pulse(input logic fast, input int k);
    if (fast) s_fast <= 1'b1;
    else s_slow <= 1'b1;
    repeat (k) @(posedge clk);
    s_fast <= 1'b0;
    s_slow <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic up;
    on_req <= 1'b1;
    waitst(4'h6);
  endtask

  // on-request low past the clear time, then raised again
  task automatic clr;
    on_req <= 1'b0;
    repeat (CLR + 5) @(posedge clk);
    chk(32'(flag_oe_n), 32'h1);
    up();
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    int          k;
    {clk, rst, psel, penable, pwrite, sup_ok, on_req, dip, s_slow, s_fast} = 10'h100;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h125E0DFE;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    // Reset values, register access and an unmapped word
    chk(32'(drv), 32'h118);
    chk(32'({pgood, flag_oe_n, irq, flag_o}), 32'h4);
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    chk(r, CTRL_RST);
    apb(1'b0, REG_IRQ_MASK, 32'h0, r, e);
    chk(r, IRQ_MASK_RST);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, r, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    k = $random(seed);
    apb(1'b1, REG_IRQ_MASK, 32'(k), r, e);
    apb(1'b0, REG_IRQ_MASK, 32'h0, r, e);
    chk(r, mask_exp(32'(k)));
    apb(1'b1, REG_IRQ_MASK, 32'h1F, r, e);
    apb(1'b1, REG_STATUS, 32'hFF, r, e);
    waitst(4'h0);
    apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
    // Supply valid, no on-request yet
    sup_ok <= 1'b1;
    waitst(4'h1);
    chk(32'(drv), 32'h118);
    on_req <= 1'b1;
    waitst(4'h3);
    chk(32'(drv.tmr_charge), 32'h1);
    waitst(4'h4);
    chk(32'(drv.tmr_discharge), 32'h1);
    waitst(4'h5);
    chk(32'({drv.gate_charge, drv.fast_armed, drv.slow_armed}), 32'h6);
    s_slow <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(drv.gate_throttle), 32'h1);
    s_slow <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(drv.gate_throttle), 32'h0);
    waitst(4'h6);
    chk(32'({pgood, drv.slow_armed, irq}), 32'h7);
    apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
    chk(r, 32'h4);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    // Fast drops just short of qualification, the longest one first
    for (int i = 0; i < 4; i++) begin
      k = (i == 0) ? 37 : 1 + {$random(seed)} % 37;
      pulse(1'b1, k);
      waitst(4'h6);
    end
    pulse(1'b1, 40);
    chk(32'({drv.gate_pulldown, drv.gate_charge, flag_oe_n}), 32'h4);
    waitst(4'h9);
    apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
    chk(r & 32'h1, 32'h1);
    // on-request low too briefly leaves the trip latched
    on_req <= 1'b0;
    repeat (CLR - 3) @(posedge clk);
    on_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(flag_oe_n), 32'h0);
    clr();
    // Slow detector with its default and with the external delay
    pulse(1'b0, 2490);
    waitst(4'h6);
    pulse(1'b0, 2510);
    waitst(4'h9);
    apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
    chk(r & 32'h2, 32'h2);
    clr();
    apb(1'b1, REG_CTRL, 32'h1, r, e);
    s_slow <= 1'b1;
    repeat (2600) @(posedge clk);
    chk(32'(drv.slow_node_charge), 32'h1);
    waitst(4'h6);
    repeat (1500) @(posedge clk);
    s_slow <= 1'b0;
    waitst(4'h9);
    apb(1'b1, REG_CTRL, 32'h0, r, e);
    clr();
    // Output dip, then a full good cycle before power-good returns
    dip <= 1'b1;
    repeat (30) @(posedge clk);
    chk(32'(pgood), 32'h0);
    dip <= 1'b0;
    waitst(4'h7);
    chk(32'(pgood), 32'h0);
    // A second dip inside the recovery cycle aborts it
    dip <= 1'b1;
    repeat (2) @(posedge clk);
    dip <= 1'b0;
    chk(32'(pgood), 32'h0);
    waitst(4'h7);
    chk(32'(pgood), 32'h0);
    waitst(4'h6);
    chk(32'(pgood), 32'h1);
    apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
    apb(1'b1, REG_IRQ_MASK, 32'h17, r, e);
    // on-request low asks for power off
    on_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(drv.gate_pulldown), 32'h1);
    waitst(4'h1);
    chk(32'({pgood, irq}), 32'h0);
    apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
    chk(r & 32'h8, 32'h8);
    apb(1'b1, REG_IRQ_MASK, 32'h1F, r, e);
    up();
    // Supply collapse in mid-run
    sup_ok <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(drv), 32'h118);
    waitst(4'h0);
    apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
    chk(r & 32'h10, 32'h10);
    results();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(8 * 40000);
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
endmodule // tb
